// [hdl/i2c_dev_end.sv]
// Purpose: slave end of the two-wire link with a 10-bit register port
// Assumes: bus clock at most a tenth of the core clock rate
// Notes:   bits are caught on the bus clock, protocol runs on core clock
//
// Functional notes
// - device is slave only, never clocks
// - master changes data only while clock low
// - data fall with clock high is START
// - data rise with clock high is STOP
// - receiver pulls data low on ninth pulse
// - withhold acknowledge when read data not ready
// - capture data on rising bus clock edge
// - first byte msb first, match 1101010
// - address byte lsb: 1 read, 0 write
// - acknowledge matching address, else stay off
// - write sends two internal address bytes first
// - low ten address bits select location
// - top address bit enables auto increment
// - acknowledge both internal address bytes
// - single byte write then STOP
// - multibyte write, every byte acknowledged
// - counter advances per byte when increment set
// - plain read returns byte at counter
// - master ends read with nack, STOP
// - random read begins with address-only write
// - repeated START with read bit returns byte
// - master ack requests next byte, nack ends
`timescale 1ns/1ps

module i2c_dev_end (
	// core clock and reset
	input  wire logic        core_clk_i,
	input  wire logic        rst_i,
	// two-wire link, clocked by its own bus clock
	i2c_link_if.dev          link,
	// register port
	output logic [9:0]       reg_addr_o,
	output logic             reg_wr_o,
	output logic [7:0]       reg_wdata_o,
	output logic             reg_rd_o,
	input  wire logic [7:0]  reg_rdata_i,
	input  wire logic        reg_rd_ready_i
);

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE   = 3'h0,
		ST_DEVSEL = 3'h1,
		ST_AHI    = 3'h2,
		ST_ALO    = 3'h3,
		ST_WDATA  = 3'h4,
		ST_READ   = 3'h5
	} dev_state_type;

	typedef struct packed {
		logic bit_v;
	} link_type;

	typedef struct packed {
		dev_state_type st;
		logic [3:0]    cnt;
		logic [7:0]    sh;
		logic          ack;
		logic          rw;
		logic          oe;
		logic [9:0]    addr;
		logic          incr;
		logic [7:0]    txb;
		logic          wr;
		logic [7:0]    wdata;
		logic          rd;
		logic          scl_d;
		logic          sda_d;
	} core_type;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [9:0] next_addr(input logic [9:0] a, input logic inc);
		next_addr = inc ? a + 10'h001 : a;
	endfunction

	// ------------------------------------------------------------
	// bus clock domain: one capture per rising edge
	// ------------------------------------------------------------
	link_type lk_r;
	link_type lk_nxt;

	// no reset here: the bus clock stops outside frames, so a reset synced
	// onto it would still be pending at the first bits and swallow one
	always_comb begin
		lk_nxt       = lk_r;
		lk_nxt.bit_v = link.sda;
	end

	always_ff @(posedge link.scl) begin
		lk_r <= lk_nxt;
	end

	// ------------------------------------------------------------
	// crossing into the core domain
	// ------------------------------------------------------------
	logic scl_s;
	logic sda_s;

	// bit_v stays put a full bus period, the synced clock rise qualifies it
	sync2 #(.W(2)) u_core_sync (
		.clk_i (core_clk_i),
		.d_i   ({link.scl, link.sda}),
		.q_o   ({scl_s, sda_s})
	);

	// ------------------------------------------------------------
	// protocol engine
	// ------------------------------------------------------------
	localparam logic [3:0] BYTE_BITS_L = i2c_link_pkg::BYTE_BITS;

	core_type r;
	core_type c;

	logic start_ev;
	logic stop_ev;
	logic fall_ev;
	logic rise_ev;

	assign start_ev = r.scl_d & scl_s & r.sda_d & ~sda_s;
	assign stop_ev  = r.scl_d & scl_s & ~r.sda_d & sda_s;
	assign fall_ev  = r.scl_d & ~scl_s;
	assign rise_ev  = ~r.scl_d & scl_s;

	always_comb begin
		logic [7:0] nb;
		nb      = {r.sh[6:0], lk_r.bit_v};
		c       = r;
		c.wr    = 1'b0;
		c.rd    = 1'b0;
		c.scl_d = scl_s;
		c.sda_d = sda_s;
		if (rst_i) begin
			c       = '0;
			c.scl_d = scl_s;
			c.sda_d = sda_s;
		end else if (start_ev) begin
			// a repeated start restarts address matching
			c.st  = ST_DEVSEL;
			c.cnt = 4'h0;
			c.oe  = 1'b0;
		end else if (stop_ev) begin
			c.st  = ST_IDLE;
			c.cnt = 4'h0;
			c.oe  = 1'b0;
		end else if (r.st != ST_IDLE) begin
			if (rise_ev && r.cnt < BYTE_BITS_L) begin
				c.sh  = nb;
				c.cnt = r.cnt + 4'h1;
				if (r.cnt == i2c_link_pkg::LAST_DATA_BIT) begin
					case (r.st)
						ST_DEVSEL: begin
							c.rw  = nb[0];
							// not-ready read data is refused up front
							c.ack = (nb[7:1] == i2c_link_pkg::DEV_ADDR) &&
								(!nb[0] || reg_rd_ready_i);
						end
						default: c.ack = 1'b1;
					endcase
				end
			end else if (rise_ev) begin
				c.cnt = i2c_link_pkg::ACK_DONE;
				case (r.st)
					ST_DEVSEL: begin
						if (!r.ack) begin
							c.st = ST_IDLE;
						end else if (r.rw) begin
							c.st   = ST_READ;
							c.txb  = reg_rdata_i;
							c.rd   = 1'b1;
							c.addr = next_addr(r.addr, r.incr);
						end else begin
							c.st = ST_AHI;
						end
					end
					ST_AHI: begin
						c.addr[9:8] = r.sh[i2c_link_pkg::HI_ADDR_W-1:0];
						c.incr      = r.sh[i2c_link_pkg::INC_BIT];
						c.st        = ST_ALO;
					end
					ST_ALO: begin
						c.addr[7:0] = r.sh;
						c.st        = ST_WDATA;
					end
					ST_WDATA: begin
						c.wr    = 1'b1;
						c.wdata = r.sh;
						c.addr  = next_addr(r.addr, r.incr);
					end
					ST_READ: begin
						if (!lk_r.bit_v) begin
							c.txb  = reg_rdata_i;
							c.rd   = 1'b1;
							c.addr = next_addr(r.addr, r.incr);
						end else begin
							c.st = ST_IDLE;
						end
					end
					default: c.st = ST_IDLE;
				endcase
			end
			if (fall_ev) begin
				// the line only moves while the bus clock is low
				if (r.cnt == i2c_link_pkg::ACK_DONE) begin
					c.cnt = 4'h0;
					c.oe  = (r.st == ST_READ) & ~r.txb[7];
				end else if (r.cnt == BYTE_BITS_L) begin
					c.oe = (r.st != ST_READ) & r.ack;
				end else if (r.st == ST_READ && r.cnt != 4'h0) begin
					c.txb = {r.txb[6:0], 1'b0};
					c.oe  = ~r.txb[6];
				end
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		r <= c;
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	// open drain: only ever pulls data low, the bus clock is input only
	assign link.dev_sda_o  = 1'b0;
	assign link.dev_sda_oe = r.oe;
	assign reg_addr_o      = r.addr;
	assign reg_wr_o        = r.wr;
	assign reg_wdata_o     = r.wdata;
	assign reg_rd_o        = r.rd;

endmodule // i2c_dev_end

// [hdl/i2c_link_pkg.sv]
// Purpose: shared constants and command codes of the two-wire register link
// Assumes: core clock of 100 MHz on both ends
// Notes:   bus clock period applies to the clock that the host end generates
package i2c_link_pkg;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CORE_CLK_NS   = 10;
	localparam int SCL_PERIOD_NS = 160;
	// four quarters make one bus clock period
	localparam int SCL_QTR_CYC   = SCL_PERIOD_NS / CORE_CLK_NS / 4;

	// ------------------------------------------------------------
	// addressing
	// ------------------------------------------------------------
	localparam logic [6:0] DEV_ADDR   = 7'h6a;
	localparam int         REG_ADDR_W = 10;
	// position of the increment flag inside the high address byte
	localparam int         INC_BIT    = 7;
	localparam int         HI_ADDR_W  = REG_ADDR_W - 8;

	// ------------------------------------------------------------
	// bit counts within one byte slot
	// ------------------------------------------------------------
	localparam logic [3:0] LAST_DATA_BIT = 4'h7;
	localparam logic [3:0] BYTE_BITS     = 4'h8;
	localparam logic [3:0] ACK_DONE      = 4'h9;

	// ------------------------------------------------------------
	// host commands
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		OP_START = 2'h0,
		OP_WRITE = 2'h1,
		OP_READ  = 2'h2,
		OP_STOP  = 2'h3
	} op_type;

endpackage

// [hdl/i2c_link_if.sv]
// Purpose: two-wire link between host end and device end
// Assumes: data line is open drain with a pull-up
// Notes:   the line level is the wired AND of both ends, low while either enable is set
`timescale 1ns/1ps

interface i2c_link_if;

	// ------------------------------------------------------------
	// wires
	// ------------------------------------------------------------
	logic scl;
	logic host_sda_o;
	logic host_sda_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic sda;

	// released line reads high, any driver pulls it to its output
	assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

	// ------------------------------------------------------------
	// ends
	// ------------------------------------------------------------
	modport dev (
		input  scl,
		input  sda,
		output dev_sda_o,
		output dev_sda_oe
	);

	modport host (
		output scl,
		output host_sda_o,
		output host_sda_oe,
		input  sda
	);

endinterface

// [hdl/sync2.sv]
// Purpose: two flip-flop synchroniser for levels
// Assumes: each bit is an independent level
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps

module sync2 #(
	parameter int W = 1
) (
	// clock
	input  wire logic         clk_i,
	// data
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);

	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] q;
	} sync_type;

	sync_type r;
	sync_type nxt;

	always_comb begin
		nxt.meta = d_i;
		nxt.q    = r.meta;
	end

	always_ff @(posedge clk_i) begin
		r <= nxt;
	end

	assign q_o = r.q;

endmodule // sync2

// [hdl/i2c_host_end.sv]
// Purpose: master end of the two-wire link driven by byte commands
// Assumes: one command at a time, no other master on the bus
// Notes:   bus clock is divided from the core clock and driven out
`timescale 1ns/1ps

module i2c_host_end (
	// core clock and reset
	input  wire logic        core_clk_i,
	input  wire logic        rst_i,
	// command port
	input  wire logic        cmd_valid_i,
	output logic             cmd_ready_o,
	input  wire logic [1:0]  cmd_op_i,
	input  wire logic [7:0]  cmd_data_i,
	input  wire logic        cmd_ack_i,
	// answer port
	output logic             done_o,
	output logic [7:0]       rdata_o,
	output logic             nack_o,
	// two-wire link
	i2c_link_if.host         link
);

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		H_IDLE  = 2'h0,
		H_START = 2'h1,
		H_XFER  = 2'h2,
		H_STOP  = 2'h3
	} host_state_type;

	typedef struct packed {
		host_state_type st;
		logic [2:0]     div;
		logic [1:0]     step;
		logic [3:0]     bitn;
		logic           scl;
		logic           oe;
		logic           rd_op;
		logic           ack_tx;
		logic [7:0]     sh;
		logic           done;
		logic [7:0]     rdata;
		logic           nack;
	} host_type;

	localparam logic [2:0] QTR_LAST = 3'(i2c_link_pkg::SCL_QTR_CYC - 1);

	logic     sda_s;
	logic     tick;
	host_type r;
	host_type c;

	sync2 #(.W(1)) u_sda_sync (
		.clk_i (core_clk_i),
		.d_i   (link.sda),
		.q_o   (sda_s)
	);

	// ------------------------------------------------------------
	// sequencer, one step per quarter of the bus clock
	// ------------------------------------------------------------
	assign tick = (r.div == QTR_LAST);

	always_comb begin
		c      = r;
		c.done = 1'b0;
		c.div  = tick ? 3'h0 : r.div + 3'h1;
		if (rst_i) begin
			// bus rests idle: clock high, data released
			c     = '0;
			c.scl = 1'b1;
		end else begin
			case (r.st)
				H_IDLE: begin
					if (cmd_valid_i) begin
						c.step   = 2'h0;
						c.bitn   = 4'h0;
						c.div    = 3'h0;
						c.sh     = cmd_data_i;
						c.ack_tx = cmd_ack_i;
						c.rd_op  = (cmd_op_i == i2c_link_pkg::OP_READ);
						case (cmd_op_i)
							i2c_link_pkg::OP_START: c.st = H_START;
							i2c_link_pkg::OP_STOP:  c.st = H_STOP;
							default:                c.st = H_XFER;
						endcase
					end
				end
				H_START: if (tick) begin
					c.step = r.step + 2'h1;
					case (r.step)
						2'h0: c.oe = 1'b0;
						2'h1: c.scl = 1'b1;
						2'h2: c.oe = 1'b1;
						default: begin
							c.scl  = 1'b0;
							c.done = 1'b1;
							c.st   = H_IDLE;
						end
					endcase
				end
				H_XFER: if (tick) begin
					c.step = r.step + 2'h1;
					case (r.step)
						2'h0: begin
							// data only changes a quarter after the fall
							if (r.bitn < i2c_link_pkg::BYTE_BITS) begin
								c.oe = ~r.rd_op & ~r.sh[7];
							end else begin
								c.oe = r.rd_op & r.ack_tx;
							end
						end
						2'h1: c.scl = 1'b1;
						2'h2: begin
							if (r.bitn < i2c_link_pkg::BYTE_BITS) begin
								c.sh = {r.sh[6:0], sda_s};
							end else if (!r.rd_op) begin
								c.nack = sda_s;
							end
						end
						default: begin
							c.scl  = 1'b0;
							c.bitn = r.bitn + 4'h1;
							if (r.bitn == i2c_link_pkg::BYTE_BITS) begin
								c.done  = 1'b1;
								c.rdata = r.sh;
								c.st    = H_IDLE;
							end
						end
					endcase
				end
				H_STOP: if (tick) begin
					c.step = r.step + 2'h1;
					case (r.step)
						2'h0: c.oe = 1'b1;
						2'h1: c.scl = 1'b1;
						2'h2: c.oe = 1'b0;
						default: begin
							c.done = 1'b1;
							c.st   = H_IDLE;
						end
					endcase
				end
				default: c.st = H_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk_i) begin
		r <= c;
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign cmd_ready_o      = (r.st == H_IDLE) & ~rst_i;
	assign done_o           = r.done;
	assign rdata_o          = r.rdata;
	assign nack_o           = r.nack;
	assign link.scl         = r.scl;
	assign link.host_sda_o  = 1'b0;
	assign link.host_sda_oe = r.oe;

endmodule // i2c_host_end

// [verif/i2c_link_chk.sv]
// Purpose: protocol assertions on the two-wire link wires
// Assumes: all wires sampled on the core clock
// Notes:   sda is the resolved line of both ends
`timescale 1ns/1ps

module i2c_link_chk (
	// core clock and reset
	input wire logic core_clk_i,
	input wire logic rst_i,
	// link wires
	input wire logic scl,
	input wire logic host_sda_o,
	input wire logic host_sda_oe,
	input wire logic dev_sda_o,
	input wire logic dev_sda_oe,
	input wire logic sda
);
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (rst_i);

	// ------
	// helper: bus clock falls since the last START
	// ------
	logic       scl_d_r;
	logic       sda_d_r;
	logic [3:0] falls_r;

	always_ff @(posedge core_clk_i) begin
		scl_d_r <= scl;
		sda_d_r <= sda;
		if (rst_i || (scl && scl_d_r && sda_d_r && !sda)) begin
			falls_r <= 4'h0;
		end else if (scl_d_r && !scl && falls_r != 4'hf) begin
			falls_r <= falls_r + 4'h1;
		end
	end

	// ------
	// assertions
	// ------
	addr_quiet_a: assert property (falls_r < 4'h9 |-> !dev_sda_oe || dev_sda_o)
		else $error("device pulls data during address byte");
	host_ack_free_a: assert property (
		scl && falls_r == 4'h9 |-> !host_sda_oe || host_sda_o)
		else $error("host holds data in address acknowledge");
	dev_change_low_a: assert property ($changed(dev_sda_oe) |-> !scl)
		else $error("device data moved with clock high");
	dev_drive_delay_a: assert property ($rose(dev_sda_oe) |->
		($past(scl, 4) || $past(scl, 5) || $past(scl, 6)))
		else $error("device drive not right after clock fall");
	no_dual_drive_a: assert property (scl |-> !(dev_sda_oe && host_sda_oe))
		else $error("both ends drive with clock high");
	host_sda_mid_a: assert property (scl && $changed(host_sda_oe) |->
		$past(scl, 4) ##0 scl [*4])
		else $error("start or stop edge not mid high phase");
	stop_quiet_a: assert property (scl && $rose(sda) |-> !dev_sda_oe [*8])
		else $error("device active after stop");
	scl_high_len_a: assert property ($rose(scl) |-> scl [*8])
		else $error("bus clock high phase short");
	scl_low_len_a: assert property ($fell(scl) |-> !scl [*8])
		else $error("bus clock low phase short");

	start_seen_c: cover property (scl && $fell(sda));
	stop_seen_c: cover property (scl && $rose(sda));
	dev_ack_c: cover property (scl && dev_sda_oe);

endmodule // i2c_link_chk

// [verif/i2c_slave_register_access_tb.sv]
// Purpose: host end and device end joined, driven by byte commands
// Assumes: register side modelled here as a 1024 byte array
// Notes:   register side answers one core cycle after the address moves
`timescale 1ns/1ps

module i2c_slave_register_access_tb;
	logic        core_clk_i  = 1'b0;
	logic        rst_i       = 1'b1;
	logic        cmd_valid_r = 1'b0;
	logic [1:0]  cmd_op_r    = 2'h0;
	logic [7:0]  cmd_data_r  = 8'h00;
	logic        cmd_ack_r   = 1'b0;
	logic        cmd_ready_o, done_o, nack_o, reg_wr_o, reg_rd_o;
	logic [7:0]  rdata_o, reg_wdata_o;
	logic [9:0]  reg_addr_o, addr_prev_r;
	logic [7:0]  reg_rdata_r = 8'h00;
	logic        rd_ready_r  = 1'b1;
	logic [8:0]  wire_sh     = 9'h000;
	logic [7:0]  mem [1024];
	logic [17:0] wr_q [$];
	logic [17:0] exp_wr [5] = '{18'h1fec0, 18'h1ffc1, 18'h200c2, 18'h0103c, 18'h0107e};
	int          num_errors  = 0;
	int          n_checks    = 0;

	i2c_link_if link ();
	i2c_host_end i_i2c_host_end (.core_clk_i(core_clk_i), .rst_i(rst_i),
		.cmd_valid_i(cmd_valid_r), .cmd_ready_o(cmd_ready_o), .cmd_op_i(cmd_op_r),
		.cmd_data_i(cmd_data_r), .cmd_ack_i(cmd_ack_r), .done_o(done_o),
		.rdata_o(rdata_o), .nack_o(nack_o), .link(link));
	i2c_dev_end i_i2c_dev_end (.core_clk_i(core_clk_i), .rst_i(rst_i), .link(link),
		.reg_addr_o(reg_addr_o), .reg_wr_o(reg_wr_o), .reg_wdata_o(reg_wdata_o),
		.reg_rd_o(reg_rd_o), .reg_rdata_i(reg_rdata_r), .reg_rd_ready_i(rd_ready_r));
	i2c_link_chk i_i2c_link_chk (.core_clk_i(core_clk_i), .rst_i(rst_i), .scl(link.scl),
		.host_sda_o(link.host_sda_o), .host_sda_oe(link.host_sda_oe),
		.dev_sda_o(link.dev_sda_o), .dev_sda_oe(link.dev_sda_oe), .sda(link.sda));

	// ------
	// register side and wire monitor
	// ------
	function automatic logic [7:0] init_val(input logic [9:0] a);
		return a[7:0] ^ 8'h5a;
	endfunction

	initial for (int i = 0; i < 1024; i++) mem[i] = init_val(10'(i));
	// written address is the counter before its advance
	always @(posedge core_clk_i) begin
		addr_prev_r <= reg_addr_o;
		reg_rdata_r <= mem[reg_addr_o];
		if (reg_wr_o === 1'b1) begin
			mem[addr_prev_r] <= reg_wdata_o;
			wr_q.push_back({addr_prev_r, reg_wdata_o});
		end
	end
	always @(posedge link.scl) wire_sh <= {wire_sh[7:0], link.sda};

	// ------
	// tasks
	// ------
	task automatic check(input string what, input logic [17:0] seen, input logic [17:0] exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// entered at a rising edge, returns at the edge after done
	task automatic cmd(input logic [1:0] op, input logic [7:0] d, input logic a);
		int n;
		n = 0;
		cmd_op_r    <= op;
		cmd_data_r  <= d;
		cmd_ack_r   <= a;
		cmd_valid_r <= 1'b1;
		@(negedge core_clk_i);
		while (cmd_ready_o !== 1'b1 && n < 300) begin
			@(negedge core_clk_i);
			n++;
		end
		@(posedge core_clk_i);
		cmd_valid_r <= 1'b0;
		@(negedge core_clk_i);
		while (done_o !== 1'b1 && n < 300) begin
			@(negedge core_clk_i);
			n++;
		end
		// a command that never finishes counts as a mismatch
		check("done", 18'(done_o), 18'h1);
		@(posedge core_clk_i);
	endtask

	task automatic wr(input logic [7:0] d, input logic exp_nack);
		cmd(i2c_link_pkg::OP_WRITE, d, 1'b0);
		check("nack", 18'(nack_o), 18'(exp_nack));
	endtask

	task automatic rd(input logic ack, input logic [7:0] exp);
		cmd(i2c_link_pkg::OP_READ, 8'h00, ack);
		check("rdata", 18'(rdata_o), 18'(exp));
	endtask

	task automatic start();
		cmd(i2c_link_pkg::OP_START, 8'h00, 1'b0);
	endtask

	task automatic stop();
		cmd(i2c_link_pkg::OP_STOP, 8'h00, 1'b0);
	endtask

	task automatic close_out();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// ------
	// sequence
	// ------
	initial forever #5 core_clk_i = ~core_clk_i;

	initial begin
		#200us;
		num_errors++;
		close_out();
	end

	initial begin
		repeat (16) @(posedge core_clk_i);
		rst_i <= 1'b0;
		@(posedge core_clk_i);
		// foreign address stays unanswered
		start();
		wr(8'haa, 1'b1);
		check("wire", 18'(wire_sh), 18'h155);
		stop();
		// incrementing burst across the 0x1ff boundary
		start();
		wr(8'hd4, 1'b0);
		check("wire", 18'(wire_sh), 18'h1a8);
		wr(8'h81, 1'b0);
		wr(8'hfe, 1'b0);
		for (int i = 0; i < 3; i++) wr(8'hc0 + 8'(i), 1'b0);
		stop();
		// fixed address: both bytes land in one place
		start();
		wr(8'hd4, 1'b0);
		wr(8'h00, 1'b0);
		wr(8'h10, 1'b0);
		wr(8'h3c, 1'b0);
		wr(8'h7e, 1'b0);
		stop();
		check("writes", 18'(wr_q.size()), 18'h5);
		for (int i = 0; i < 5; i++) check("write", wr_q[i], exp_wr[i]);
		start();
		wr(8'hd5, 1'b0);
		rd(1'b1, 8'h7e);
		rd(1'b0, 8'h7e);
		stop();
		// random read then sequential bytes
		start();
		wr(8'hd4, 1'b0);
		wr(8'h82, 1'b0);
		wr(8'h00, 1'b0);
		start();
		wr(8'hd5, 1'b0);
		rd(1'b1, 8'hc2);
		rd(1'b1, init_val(10'h201));
		rd(1'b0, init_val(10'h202));
		stop();
		// counter carries into the next plain read
		start();
		wr(8'hd5, 1'b0);
		rd(1'b0, init_val(10'h203));
		stop();
		// read data not available
		rd_ready_r <= 1'b0;
		start();
		wr(8'hd5, 1'b1);
		stop();
		rd_ready_r <= 1'b1;
		close_out();
	end

endmodule // i2c_slave_register_access_tb
